// ===== core/clk_ctrl.v
/*
  Clock control register block: source switch request, clock-fail flag with trap,
  doze ratio with recover-on-interrupt, RC postscaler, PLL dividers and RC trim.
  Assumes a single-cycle register port on clk_i, and fail/interrupt inputs from
  logic on the same clock; the source-ready input comes from the analog side.
*/
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"

module clk_ctrl #(
  parameter ADDR_W = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Register port
  input wire [ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Events
  input wire monitor_fail_i,
  input wire irq_i,
  input wire src_ready_i,
  input wire pll_lock_i,
  // Clock controls
  output reg [2:0] cur_src_o,
  output reg osc_trap_o,
  output reg [7:0] doze_div_o,
  output reg [8:0] rc_div_o,
  output reg [3:0] pll_pre_div_o,
  output reg [7:0] pll_fbd_o,
  output reg [2:0] vco_div_o,
  output reg [2:0] post1_o,
  output reg [2:0] post2_o,
  output reg [5:0] rc_trim_o
);

  localparam integer WAIT_CYC_I = `SWITCH_WAIT_NS / `CLK_PERIOD_NS;
  localparam [7:0] WAIT_CYC = WAIT_CYC_I[7:0];

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // ----------------------------------------
  // Synchronise analog ready/lock
  // ----------------------------------------
  reg rdy_s1_r, rdy_s2_r, lock_s1_r, lock_s2_r;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      rdy_s1_r <= src_ready_i;
      rdy_s2_r <= rdy_s1_r;
      lock_s1_r <= pll_lock_i;
      lock_s2_r <= lock_s1_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] cur_r, new_r, state_r;
  reg clk_lock_r, fail_r, sw_req_r;
  reg roi_r, doze_en_r;
  reg [2:0] doze_r, rcdiv_r;
  reg [3:0] pre_r;
  reg [7:0] fbd_r;
  reg [5:0] trim_r;
  reg [1:0] vco_r;
  reg [2:0] p1_r, p2_r;
  reg [1:0] hi_key_r, lo_key_r;
  reg [7:0] wait_r;

  wire wr_osc = wr_i && (addr_i == `OSC_CTRL_ADDR);
  wire wr_div = wr_i && (addr_i == `CLK_DIV_ADDR);
  // A write that carries a key, or any other write, consumes the unlock window
  wire hi_open = hi_key_r[1];
  wire lo_open = lo_key_r[1];
  wire sw_fail = wr_osc && lo_open && wdata_i[3] && !fail_r;
  wire [2:0] tgt = (new_r == `SRC_RSVD) ? `SRC_FRC : new_r;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_key_r <= 2'h0;
      lo_key_r <= 2'h0;
    end else if (wr_osc) begin
      // Keys must be back to back; a stray write drops the sequence
      if (wdata_i[15:8] == `KEY_HI_1) hi_key_r <= 2'h1;
      else if (hi_key_r == 2'h1 && wdata_i[15:8] == `KEY_HI_2) hi_key_r <= 2'h2;
      else hi_key_r <= 2'h0;
      if (wdata_i[7:0] == `KEY_LO_1) lo_key_r <= 2'h1;
      else if (lo_key_r == 2'h1 && wdata_i[7:0] == `KEY_LO_2) lo_key_r <= 2'h2;
      else lo_key_r <= 2'h0;
    end else if (wr_i) begin
      hi_key_r <= 2'h0;
      lo_key_r <= 2'h0;
    end
  end

  // ----------------------------------------
  // Oscillator control and switch sequencer
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_r <= `SRC_RESET;
      new_r <= `SRC_RESET;
      clk_lock_r <= 1'b0;
      fail_r <= 1'b0;
      sw_req_r <= 1'b0;
      state_r <= ST_IDLE;
      wait_r <= 8'h00;
      osc_trap_o <= 1'b0;
    end else begin
      osc_trap_o <= monitor_fail_i || sw_fail;
      if (wr_osc && hi_open) new_r <= wdata_i[10:8];
      if (wr_osc && lo_open) clk_lock_r <= wdata_i[7];
      // Hardware set wins over a software clear in the same cycle
      if (monitor_fail_i) fail_r <= 1'b1;
      else if (wr_osc && lo_open) fail_r <= wdata_i[3];
      case (state_r)
        ST_IDLE: begin
          if (wr_osc && lo_open && wdata_i[0]) begin
            sw_req_r <= 1'b1;
            wait_r <= WAIT_CYC;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Old source keeps running until the new one reports ready
          if (wait_r != 8'h00) wait_r <= wait_r - 8'h01;
          else if (rdy_s2_r) begin
            cur_r <= tgt;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          sw_req_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Clock divider and PLL registers
  // ----------------------------------------
  wire [2:0] doze_w = wdata_i[14:12];
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      roi_r <= 1'b0;
      doze_r <= `DOZE_RESET;
      doze_en_r <= 1'b0;
      rcdiv_r <= `RCDIV_RESET;
      pre_r <= `PRE_RESET;
      fbd_r <= `FBD_RESET;
      trim_r <= 6'h00;
      vco_r <= `VCO_OUTPUT_DIVIDER_RESET;
      p1_r <= `POST1_RESET;
      p2_r <= `POST2_RESET;
    end else begin
      if (wr_div) begin
        roi_r <= wdata_i[15];
        rcdiv_r <= wdata_i[10:8];
        pre_r <= wdata_i[3:0];
        if (!doze_en_r) doze_r <= doze_w;
        // Enable test uses the field as it will stand after this write
        if (!wdata_i[11]) doze_en_r <= 1'b0;
        else if ((doze_en_r ? doze_r : doze_w) != 3'h0) doze_en_r <= 1'b1;
      end
      if (roi_r && irq_i) doze_en_r <= 1'b0;
      if (wr_i && addr_i == `PLL_FBD_ADDR) fbd_r <= wdata_i[7:0];
      if (wr_i && addr_i == `RC_TUNE_ADDR) trim_r <= wdata_i[5:0];
      if (wr_i && addr_i == `PLL_ODIV_ADDR) begin
        vco_r <= wdata_i[9:8];
        p1_r <= wdata_i[6:4];
        p2_r <= wdata_i[2:0];
      end
    end
  end

  // ----------------------------------------
  // Decoded outputs and read port
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
      cur_src_o <= `SRC_RESET;
      doze_div_o <= 8'h01;
      rc_div_o <= 9'h001;
      pll_pre_div_o <= `PRE_RESET;
      pll_fbd_o <= `FBD_RESET;
      vco_div_o <= 3'h4;
      post1_o <= `POST1_RESET;
      post2_o <= `POST2_RESET;
      rc_trim_o <= 6'h00;
    end else begin
      cur_src_o <= cur_r;
      doze_div_o <= doze_en_r ? (8'h01 << doze_r) : 8'h01;
      rc_div_o <= (rcdiv_r == 3'h7) ? 9'h100 : (9'h001 << rcdiv_r);
      pll_pre_div_o <= pre_r;
      pll_fbd_o <= fbd_r;
      vco_div_o <= 3'h4 - {1'b0, vco_r};
      post1_o <= p1_r;
      post2_o <= p2_r;
      rc_trim_o <= trim_r;
      rdata_o <= 16'h0000;
      if (rd_i) begin
        case (addr_i)
          `OSC_CTRL_ADDR: rdata_o <= {1'b0, cur_r, 1'b0, new_r, clk_lock_r, 1'b0, lock_s2_r, 1'b0,
                                      fail_r, 2'b00, sw_req_r};
          `CLK_DIV_ADDR: rdata_o <= {roi_r, doze_r, doze_en_r, rcdiv_r, 4'h0, pre_r};
          `PLL_FBD_ADDR: rdata_o <= {8'h00, fbd_r};
          `RC_TUNE_ADDR: rdata_o <= {10'h000, trim_r};
          `PLL_ODIV_ADDR: rdata_o <= {6'h00, vco_r, 1'b0, p1_r, 1'b0, p2_r};
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ===== core/clk_ctrl_defs.vh
/*
  Register map, source codes, reset values, unlock keys and switch timing of the clock control block.
  Assumes inclusion by the clock control module only.
*/
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OSC_CTRL_ADDR 4'h0
`define CLK_DIV_ADDR 4'h1
`define PLL_FBD_ADDR 4'h2
`define RC_TUNE_ADDR 4'h3
`define PLL_ODIV_ADDR 4'h4
`define HOLD_ADDR 4'h5

// ----------------------------------------
// Unlock keys
// ----------------------------------------
`define KEY_HI_1 8'h78
`define KEY_HI_2 8'h9a
`define KEY_LO_1 8'h46
`define KEY_LO_2 8'h57

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRC_RESET 3'h7
`define DOZE_RESET 3'h3
`define RCDIV_RESET 3'h0
`define PRE_RESET 4'h1
`define FBD_RESET 8'h96
`define VCO_OUTPUT_DIVIDER_RESET 2'h0
`define POST1_RESET 3'h4
`define POST2_RESET 3'h1

// ----------------------------------------
// Source codes
// ----------------------------------------
`define SRC_FRC 3'h0
`define SRC_FRC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_RSVD 3'h4

// ----------------------------------------
// Switch timing (source ready wait)
// ----------------------------------------
`define SWITCH_WAIT_NS 100
`define CLK_PERIOD_NS 5

`endif

// ===== sim/clk_ctrl_properties.sv
/* Port checker for the clock control block.
   Assumes it is bound to clk_ctrl and sees only its ports. */
`timescale 1ns/1ps
module clk_ctrl_properties #(
  parameter ADDR_W = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Register port
  input wire [ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // Events and controls
  input wire monitor_fail_i,
  input wire osc_trap_o,
  input wire [2:0] cur_src_o,
  input wire [7:0] doze_div_o,
  input wire [8:0] rc_div_o,
  input wire [2:0] vco_div_o,
  input wire [2:0] post1_o,
  input wire [2:0] post2_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  trap_on_fail_a: assert property (monitor_fail_i |=> osc_trap_o)
    else $error("trap missing after monitor failure");
  trap_cause_a: assert property (osc_trap_o |-> $past(monitor_fail_i) || $past(wr_i && wdata_i[3]))
    else $error("trap without a cause");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0)
    else $error("read data outside read cycle");
  doze_ratio_a: assert property ($onehot(doze_div_o))
    else $error("doze ratio not a power of two");
  rc_ratio_a: assert property ($onehot(rc_div_o) && !rc_div_o[7])
    else $error("rc postscaler ratio illegal");
  vco_ratio_a: assert property (vco_div_o inside {[3'h1:3'h4]})
    else $error("vco ratio out of range");
  src_reserved_a: assert property (cur_src_o != 3'h4)
    else $error("reserved source became current");
  out_reset_a: assert property ($rose(nrst_i) |-> post1_o == 3'h4 && post2_o == 3'h1)
    else $error("output divider reset values wrong");
  // Main scenarios
  cover property (osc_trap_o);
  cover property ($changed(cur_src_o));
  cover property (doze_div_o == 8'h20);
endmodule
bind clk_ctrl clk_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .monitor_fail_i(monitor_fail_i),
  .osc_trap_o(osc_trap_o), .cur_src_o(cur_src_o), .doze_div_o(doze_div_o), .rc_div_o(rc_div_o),
  .vco_div_o(vco_div_o), .post1_o(post1_o), .post2_o(post2_o));

// ===== sim/oscillator_pll_doze_control_bench.sv
/* Self-checking bench for clk_ctrl.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
module oscillator_pll_doze_control_bench;
  reg clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, monitor_fail_i = 1'b0, irq_i = 1'b0;
  reg src_ready_i = 1'b0, pll_lock_i = 1'b0;
  reg [3:0] addr_i = 4'h0, p;
  reg [15:0] wdata_i = 16'h0, rd_v;
  reg [31:0] r = 32'h909bd9bd;
  reg [2:0] s, e, c, d, a, b, ce = 3'h7;
  reg [1:0] v;
  reg [7:0] f;
  wire [15:0] rdata_o;
  wire [2:0] cur_src_o, vco_div_o, post1_o, post2_o;
  wire [7:0] doze_div_o, pll_fbd_o;
  wire [8:0] rc_div_o;
  wire [3:0] pll_pre_div_o;
  wire [5:0] rc_trim_o;
  wire osc_trap_o;
  integer errors = 0, comparisons = 0, i, j;
  localparam [26:0] SEQ = {3'h2, 3'h0, 3'h1, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  clk_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .monitor_fail_i(monitor_fail_i), .irq_i(irq_i), .src_ready_i(src_ready_i),
    .pll_lock_i(pll_lock_i), .cur_src_o(cur_src_o), .osc_trap_o(osc_trap_o), .doze_div_o(doze_div_o),
    .rc_div_o(rc_div_o), .pll_pre_div_o(pll_pre_div_o), .pll_fbd_o(pll_fbd_o), .vco_div_o(vco_div_o),
    .post1_o(post1_o), .post2_o(post2_o), .rc_trim_o(rc_trim_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task chk(input string n, input [15:0] ex, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== ex) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", n, ex, g);
      end
    end
  endtask
  task wr(input [3:0] ad, input [15:0] dt);
    begin
      @(posedge clk_i); wr_i <= 1'b1; addr_i <= ad; wdata_i <= dt;
      @(posedge clk_i); wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad);
    begin
      @(posedge clk_i); rd_i <= 1'b1; addr_i <= ad;
      @(posedge clk_i); rd_i <= 1'b0;
      #1 rd_v = rdata_o;
    end
  endtask
  // Keys for both bytes precede every control write
  task osc(input [15:0] dt);
    begin
      wr(0, 16'h7846); wr(0, 16'h9a57); wr(0, dt);
    end
  endtask
  task pulse_irq;
    begin
      @(posedge clk_i); irq_i <= 1'b1;
      @(posedge clk_i); irq_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    test_done;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(1); chk("clock_divider_control", 16'h3001, rd_v);
    rd(2); chk("fbd", 16'h0096, rd_v);
    rd(4); chk("pll_output_divider", 16'h0041, rd_v);
    rd(4'hf); chk("unmapped", 16'h0, rd_v);
    $display("done reset");
    for (j = 8; j >= 0; j = j - 1) begin
      s = SEQ[3*j +: 3];
      e = (s == 3'h4) ? 3'h0 : s;
      @(posedge clk_i); src_ready_i <= 1'b0;
      osc({5'h0, s, 8'h01});
      repeat (30) @(posedge clk_i);
      rd(0); chk("hold", {13'h0, ce}, {13'h0, cur_src_o});
      chk("busy", 16'h1, rd_v & 16'h1);
      @(posedge clk_i); src_ready_i <= 1'b1;
      for (i = 0; i < 20 && rd_v[0] !== 1'b0; i = i + 1) rd(0);
      chk("osc", {1'b0, e, 1'b0, s, 8'h0}, rd_v & 16'h7709);
      ce = e;
    end
    $display("done switch");
    wr(0, 16'h0201); settle; rd(0); chk("locked", 16'h7700, rd_v & 16'h7709);
    wr(0, 16'h7800); wr(0, 16'h9a00); wr(0, 16'h0001); rd(0); chk("hikey", 16'h7000, rd_v & 16'h7709);
    @(posedge clk_i); monitor_fail_i <= 1'b1;
    @(posedge clk_i); monitor_fail_i <= 1'b0;
    #1 chk("trap", 16'h1, {15'h0, osc_trap_o});
    rd(0); chk("fail", 16'h0008, rd_v & 16'h0008);
    osc(16'h0700); rd(0); chk("clear", 16'h7700, rd_v & 16'h7709);
    osc(16'h0708); #1 chk("swtrap", 16'h1, {15'h0, osc_trap_o});
    rd(0); chk("swset", 16'h7708, rd_v & 16'h7709);
    $display("done flag");
    wr(1, 16'h5001); settle; chk("dz1", 16'h1, doze_div_o);
    wr(1, 16'h5801); settle; chk("dz32", 16'h20, doze_div_o);
    wr(1, 16'h2801); rd(1); chk("dzlock", 16'h5801, rd_v);
    pulse_irq; chk("noroi", 16'h20, doze_div_o);
    wr(1, 16'hd801); pulse_irq; chk("roi", 16'h1, doze_div_o);
    rd(1); chk("roireg", 16'hd001, rd_v);
    wr(1, 16'h0001); wr(1, 16'h0801); rd(1); chk("dz0", 16'h0001, rd_v);
    $display("done doze");
    for (j = 0; j < 16; j = j + 1) begin
      r = xs(r);
      {c, d, v} = r[7:0];
      p = {1'b0, r[10:8]} + 4'h1;
      f = 8'd16 + {1'b0, r[17:11]};
      a = r[20:18] | 3'h4;
      b = {1'b0, r[22:21]} + 3'h1;
      pll_lock_i <= r[23];
      wr(1, {1'b0, c, 1'b0, d, 4'h0, p});
      wr(1, {1'b0, c, 1'b1, d, 4'h0, p});
      wr(2, {8'h0, f});
      wr(3, {10'h0, r[29:24]});
      pll_lock_i <= 1'b0;
      wr(4, {6'h0, v, 1'b0, a, 1'b0, b});
      pll_lock_i <= r[23];
      settle;
      chk("doze", (c == 3'h0) ? 16'h1 : 16'h1 << c, doze_div_o);
      chk("rcdiv", (d == 3'h7) ? 16'h100 : 16'h1 << d, rc_div_o);
      chk("pre", p, pll_pre_div_o);
      chk("fbdo", f, pll_fbd_o);
      chk("trim", r[29:24], rc_trim_o);
      chk("vco", 16'h4 - v, vco_div_o);
      chk("post", {a, b}, {post1_o, post2_o});
      rd(1); chk("cdreg", {1'b0, c, c != 3'h0, d, 4'h0, p}, rd_v);
    end
    $display("done random");
    test_done;
  end
endmodule
